// file: verilog/mic_interrupt_controller.sv
`timescale 1ns/1ps
`include "mic_defs.svh"
// What this block does
// R01 - finish current instruction before interrupt entry
// R02 - push program counter, index, accumulator, flags
// R03 - five bytes, low PC first, decrement after
// R04 - set mask bit on entry
// R05 - load vector of selected source
// R06 - return pops context, restoring mask bit
// R07 - cleared mask lets pending requests in
// R08 - masked requests stay pending until unmasked
// R09 - fixed priority picks among pending requests
// R10 - reset, trap, then descending vector address
// R11 - trap enters regardless of mask bit
// R12 - four external lines and their vectors
// R13 - peripheral vectors, one per peripheral
// R14 - wait wakes on any, halt external only
// R15 - edge latch clears on routine entry
// R16 - enabled pins of a group combine
// R17 - low enabled pin masks group request
// R18 - two-bit polarity field selects sensitivity
// R19 - peripheral needs mask clear and enable
// R20 - disabled peripheral request stays latched
// R21 - software clears peripheral flag by sequence
// R22 - clear sequence drops pending request
module mic_interrupt_controller
    import mic_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        INSN_DONE,
    input  wire logic        TRAP_REQ,
    input  wire logic        RETURN_FROM_INTERRUPT_REQ,
    input  wire logic        WFI_REQ,
    input  wire logic        HALT_REQ,
    input  wire logic        MASK_SET,
    input  wire logic        MASK_CLR,
    input  wire logic [15:0] PC_IN,
    input  wire logic [7:0]  X_IN,
    input  wire logic [7:0]  A_IN,
    input  wire logic [7:0]  CC_IN,
    input  wire logic [7:0]  SP_IN,
    input  wire logic [3:0]  PA_PIN,
    input  wire logic [3:0]  PA_IEN,
    input  wire logic [2:0]  PF_PIN,
    input  wire logic [2:0]  PF_IEN,
    input  wire logic [7:0]  PB_PIN,
    input  wire logic [7:0]  PB_IEN,
    input  wire logic [4:0]  PER_SET,
    input  wire logic [4:0]  PER_CLR,
    input  wire logic [4:0]  PER_IE,
    input  wire logic [7:0]  STK_RDATA,
    output logic             STK_WE,
    output logic             STK_RE,
    output logic      [15:0] STK_ADDR,
    output logic      [7:0]  STK_WDATA,
    output logic             CPU_HOLD,
    output logic             PC_LOAD,
    output logic      [15:0] PC_NEW,
    output logic             CTX_LOAD,
    output logic      [7:0]  X_OUT,
    output logic      [7:0]  A_OUT,
    output logic      [7:0]  CC_OUT,
    output logic             SP_LOAD,
    output logic      [7:0]  SP_OUT,
    output logic             I_MASK,
    output logic             WAKE
);

// ****************************************
// sources and priority
// ****************************************
mic_state_t              state_r;
logic       [2:0]        cnt_r;
logic       [3:0]        ctrl_r;
logic                    i_mask_r;
logic                    trap_r;
logic       [4:0]        per_r;
logic       [3:0]        edge_r;
logic       [3:0]        ext_pend;
logic       [3:0]        line_q;
logic       [7:0]        gpin [4];
logic       [7:0]        gien [4];
logic       [`MIC_NSRC-1:0] req;
logic                    req_any;
mic_src_t                pick;
mic_src_t                src_r;
logic       [7:0]        sp_r;
logic       [7:0]        ctx_r [5];
logic                    re_d;
logic       [2:0]        idx_d;
logic       [15:0]       last_vec_r;

// unused pins read as high with interrupt off
assign gpin[0] = {4'hF, PA_PIN};
assign gien[0] = {4'h0, PA_IEN};
assign gpin[1] = {5'h1F, PF_PIN};
assign gien[1] = {5'h00, PF_IEN};
assign gpin[2] = {4'hF, PB_PIN[3:0]};
assign gien[2] = {4'h0, PB_IEN[3:0]};
assign gpin[3] = {4'hF, PB_PIN[7:4]};
assign gien[3] = {4'h0, PB_IEN[7:4]};

// one group per external line
for (genvar g = 0; g < 4; g++) begin : g_ext
    logic       line;
    logic       any_en;
    logic [1:0] pol;
    logic       hit;
    assign line   = &(gpin[g] | ~gien[g]); // R16 R17
    assign any_en = |gien[g];
    assign pol    = (g < 2) ? ctrl_r[1:0] : ctrl_r[3:2];
    // R18
    always_comb begin
        case (pol)
            `MIC_POL_RISE: hit = ~line_q[g] & line;
            `MIC_POL_BOTH: hit = line_q[g] ^ line;
            default:       hit = line_q[g] & ~line;
        endcase
    end
    // edge latch; a new edge beats the entry clear
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            edge_r[g] <= 1'b0;
            line_q[g] <= 1'b1;
        end else begin
            line_q[g] <= line;
            if (hit)
                edge_r[g] <= 1'b1;
            else if (state_r == ST_VEC
                     && src_r == `MIC_SRC_EXT0 + 4'(g))
                edge_r[g] <= 1'b0; // R15
        end
    end
    assign ext_pend[g] = edge_r[g]
        | (pol == `MIC_POL_LVL && any_en && !line);
end

// peripheral latches; set wins over clear
always_ff @(posedge MCLK or posedge RST) begin
    if (RST)
        per_r <= 5'h00;
    else
        per_r <= (per_r & ~PER_CLR) | PER_SET; // R20 R22
end

// trap is held until its vector is loaded
always_ff @(posedge MCLK or posedge RST) begin
    if (RST)
        trap_r <= 1'b0;
    else if (TRAP_REQ)
        trap_r <= 1'b1;
    else if (state_r == ST_VEC && src_r == `MIC_SRC_TRAP)
        trap_r <= 1'b0;
end

// requests gated by mask and enables, except trap, which is never gated
assign req[0]   = trap_r; // R11
assign req[4:1] = ext_pend & {4{~i_mask_r}}; // R08 R07
assign req[9:5] = per_r & PER_IE & {5{~i_mask_r}}; // R19
assign req_any  = |req;

// lowest index wins
always_comb begin
    pick = `MIC_SRC_TRAP;
    for (int k = `MIC_NSRC - 1; k >= 0; k--)
        if (req[k])
            pick = 4'(k); // R09 R10
end

function automatic logic [15:0] vec_of(mic_src_t s);
    case (s)
        4'h0:    return `MIC_VEC_TRAP;
        4'h1:    return `MIC_VEC_EXT0; // R12
        4'h2:    return `MIC_VEC_EXT1;
        4'h3:    return `MIC_VEC_EXT2;
        4'h4:    return `MIC_VEC_EXT3;
        4'h5:    return `MIC_VEC_SPI; // R13
        4'h6:    return `MIC_VEC_TMA;
        4'h7:    return `MIC_VEC_TMB;
        4'h8:    return `MIC_VEC_SCI;
        default: return `MIC_VEC_NVM;
    endcase
endfunction

// ****************************************
// entry, return and sleep sequencing
// ****************************************
logic take;
// halt wakes on external lines only
assign take = (state_r == ST_IDLE && INSN_DONE && req_any) // R01
    || (state_r == ST_WAIT && req_any) // R14
    || (state_r == ST_HALT && |ext_pend); // R14

always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
        state_r <= ST_IDLE;
        cnt_r   <= 3'd0;
        src_r   <= `MIC_SRC_TRAP;
    end else begin
        case (state_r)
            ST_IDLE: begin
                cnt_r <= 3'd0;
                if (WFI_REQ)
                    state_r <= ST_WAIT;
                else if (HALT_REQ)
                    state_r <= ST_HALT;
                else if (RETURN_FROM_INTERRUPT_REQ)
                    state_r <= ST_POP;
                else if (take) begin
                    state_r <= ST_PUSH;
                    src_r   <= pick;
                end
            end
            ST_WAIT, ST_HALT: begin
                cnt_r <= 3'd0;
                if (take) begin
                    state_r <= ST_PUSH;
                    src_r   <= pick;
                end
            end
            ST_PUSH: begin
                cnt_r <= cnt_r + 3'd1;
                if (cnt_r == `MIC_PUSH_LAST)
                    state_r <= ST_VEC;
            end
            ST_POP: begin
                cnt_r <= cnt_r + 3'd1;
                if (cnt_r == `MIC_POP_LAST)
                    state_r <= ST_RET;
            end
            default: state_r <= ST_IDLE;
        endcase
    end
end

// context captured when the entry is taken
always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
        for (int k = 0; k < 5; k++)
            ctx_r[k] <= 8'h00;
    end else if (take && !(state_r == ST_IDLE
                 && (WFI_REQ || HALT_REQ || RETURN_FROM_INTERRUPT_REQ))) begin
        ctx_r[0] <= PC_IN[7:0]; // R02
        ctx_r[1] <= PC_IN[15:8];
        ctx_r[2] <= X_IN;
        ctx_r[3] <= A_IN;
        ctx_r[4] <= CC_IN;
        ctx_r[4][`MIC_CC_I] <= i_mask_r;
    end else if (re_d) begin
        ctx_r[idx_d] <= STK_RDATA;
    end
end

// stack traffic; pointer stays inside its page
always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
        sp_r      <= 8'h00;
        STK_WE    <= 1'b0;
        STK_RE    <= 1'b0;
        STK_ADDR  <= 16'h0000;
        STK_WDATA <= 8'h00;
        re_d      <= 1'b0;
        idx_d     <= 3'd0;
    end else begin
        STK_WE <= 1'b0;
        STK_RE <= 1'b0;
        re_d   <= STK_RE;
        idx_d  <= `MIC_PUSH_LAST - cnt_r + 3'd1;
        if (state_r == ST_IDLE)
            sp_r <= SP_IN;
        if (state_r == ST_PUSH) begin
            STK_WE    <= 1'b1; // R03
            STK_ADDR  <= {`MIC_STK_HI, sp_r};
            STK_WDATA <= ctx_r[cnt_r];
            sp_r      <= sp_r - 8'h01;
        end else if (state_r == ST_POP
                     && cnt_r <= `MIC_PUSH_LAST) begin
            // increment before each pop, flags first
            STK_RE   <= 1'b1;
            STK_ADDR <= {`MIC_STK_HI, sp_r + 8'h01};
            sp_r     <= sp_r + 8'h01;
        end
    end
end

// mask bit; sleep clears it so requests can wake
always_ff @(posedge MCLK or posedge RST) begin
    if (RST)
        i_mask_r <= 1'b1;
    else if (state_r == ST_VEC)
        i_mask_r <= 1'b1; // R04
    else if (state_r == ST_RET)
        i_mask_r <= ctx_r[4][`MIC_CC_I]; // R06
    else if (state_r == ST_IDLE && (WFI_REQ || HALT_REQ))
        i_mask_r <= 1'b0;
    else if (state_r == ST_IDLE && MASK_SET)
        i_mask_r <= 1'b1;
    else if (state_r == ST_IDLE && MASK_CLR)
        i_mask_r <= 1'b0; // R07
end

// hand-over to the core
always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
        PC_LOAD    <= 1'b0;
        PC_NEW     <= 16'h0000;
        CTX_LOAD   <= 1'b0;
        X_OUT      <= 8'h00;
        A_OUT      <= 8'h00;
        CC_OUT     <= 8'h00;
        SP_LOAD    <= 1'b0;
        SP_OUT     <= 8'h00;
        WAKE       <= 1'b0;
        last_vec_r <= 16'h0000;
    end else begin
        PC_LOAD  <= 1'b0;
        CTX_LOAD <= 1'b0;
        SP_LOAD  <= 1'b0;
        WAKE     <= take && state_r != ST_IDLE;
        if (state_r == ST_VEC) begin
            PC_LOAD    <= 1'b1; // R05
            PC_NEW     <= vec_of(src_r);
            last_vec_r <= vec_of(src_r);
            SP_LOAD    <= 1'b1;
            SP_OUT     <= sp_r;
        end else if (state_r == ST_RET) begin
            PC_LOAD  <= 1'b1; // R06
            PC_NEW   <= {ctx_r[1], ctx_r[0]};
            CTX_LOAD <= 1'b1;
            X_OUT    <= ctx_r[2];
            A_OUT    <= ctx_r[3];
            CC_OUT   <= ctx_r[4];
            SP_LOAD  <= 1'b1;
            SP_OUT   <= sp_r;
        end
    end
end

assign CPU_HOLD = state_r != ST_IDLE;
assign I_MASK   = i_mask_r;

// ****************************************
// bus slave, zero wait states
// ****************************************
logic       acc;
logic       wr_r;
logic [7:0] wadr_r;
logic [3:0] ctrl_now;
assign acc       = HSEL && HTRANS[1] && HREADY;
assign HREADYOUT = 1'b1;
assign HRESP     = 1'b0;
// forward a write in flight to a read behind it
assign ctrl_now = (wr_r && wadr_r == `MIC_OFF_CTRL)
                ? HWDATA[3:0] : ctrl_r;

always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
        wr_r   <= 1'b0;
        wadr_r <= 8'h00;
        ctrl_r <= `MIC_CTRL_RST;
        HRDATA <= 32'h0000_0000;
    end else begin
        wr_r <= acc && HWRITE;
        if (acc)
            wadr_r <= HADDR[7:0];
        ctrl_r <= ctrl_now;
        if (acc && !HWRITE) begin
            if (HADDR[7:0] == `MIC_OFF_CTRL)
                HRDATA <= {28'h0, ctrl_now};
            else if (HADDR[7:0] == `MIC_OFF_STAT)
                HRDATA <= {20'h0, CPU_HOLD, i_mask_r,
                           per_r, ext_pend, trap_r};
            else if (HADDR[7:0] == `MIC_OFF_VEC)
                HRDATA <= {16'h0, last_vec_r};
            else
                HRDATA <= 32'h0000_0000;
        end
    end
end

// ****************************************
// checks
// ****************************************
property p_boundary;
    @(posedge MCLK) disable iff (RST)
    (state_r == ST_IDLE && !INSN_DONE) |=> state_r != ST_PUSH;
endproperty
a_boundary: assert property (p_boundary) // R01
    else $error("entry before instruction end");

property p_five;
    @(posedge MCLK) disable iff (RST)
    (state_r == ST_PUSH && cnt_r == 3'd0)
        |=> STK_WE [*5] ##1 !STK_WE;
endproperty
a_five: assert property (p_five) // R03
    else $error("entry did not push five bytes");

property p_pcl_first;
    @(posedge MCLK) disable iff (RST)
    (state_r == ST_PUSH && cnt_r == 3'd0)
        |=> STK_WDATA == ctx_r[0]
            && STK_ADDR[7:0] == $past(sp_r);
endproperty
a_pcl_first: assert property (p_pcl_first) // R03
    else $error("low pc byte not first at pointer");

property p_mask_set;
    @(posedge MCLK) disable iff (RST)
    state_r == ST_VEC |=> I_MASK && state_r == ST_IDLE;
endproperty
a_mask_set: assert property (p_mask_set) // R04
    else $error("mask not set on entry");

property p_vector;
    @(posedge MCLK) disable iff (RST)
    state_r == ST_VEC |=> PC_LOAD && PC_NEW == vec_of(src_r);
endproperty
a_vector: assert property (p_vector) // R05
    else $error("wrong vector loaded");

property p_masked;
    @(posedge MCLK) disable iff (RST)
    (state_r == ST_IDLE && I_MASK && !trap_r)
        |=> state_r != ST_PUSH;
endproperty
a_masked: assert property (p_masked) // R08
    else $error("entry while masked");

property p_halt;
    @(posedge MCLK) disable iff (RST)
    (state_r == ST_HALT && ext_pend == 4'h0)
        |=> state_r == ST_HALT;
endproperty
a_halt: assert property (p_halt) // R14
    else $error("halt left without external line");

property p_restore;
    @(posedge MCLK) disable iff (RST)
    state_r == ST_RET |=> CTX_LOAD && PC_LOAD
        && I_MASK == CC_OUT[`MIC_CC_I];
endproperty
a_restore: assert property (p_restore) // R06
    else $error("return did not restore context");

endmodule

// file: include/mic_defs.svh
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH
// register offsets
`define MIC_OFF_CTRL   8'h00
`define MIC_OFF_STAT   8'h04
`define MIC_OFF_VEC    8'h08
`define MIC_CTRL_RST   4'h0
// stack page and context
`define MIC_STK_HI     8'h01
`define MIC_CC_I       3
`define MIC_PUSH_LAST  3'd4
`define MIC_POP_LAST   3'd6
// source indices, trap first
`define MIC_SRC_TRAP   4'd0
`define MIC_SRC_EXT0   4'd1
`define MIC_SRC_EXT3   4'd4
`define MIC_NSRC       10
// vectors
`define MIC_VEC_TRAP   16'hFFFC
`define MIC_VEC_EXT0   16'hFFF6
`define MIC_VEC_EXT1   16'hFFF4
`define MIC_VEC_EXT2   16'hFFF2
`define MIC_VEC_EXT3   16'hFFF0
`define MIC_VEC_SPI    16'hFFEC
`define MIC_VEC_TMA    16'hFFEA
`define MIC_VEC_TMB    16'hFFE8
`define MIC_VEC_SCI    16'hFFE6
`define MIC_VEC_NVM    16'hFFE4
// polarity field codes
`define MIC_POL_LVL    2'b00
`define MIC_POL_FALL   2'b10
`define MIC_POL_RISE   2'b01
`define MIC_POL_BOTH   2'b11
`endif

// file: include/mic_pkg.sv
package mic_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_PUSH, ST_VEC, ST_POP,
        ST_RET, ST_WAIT, ST_HALT
    } mic_state_t;
    typedef logic [3:0] mic_src_t;
endpackage

// file: verif/mic_stack_model.sv
`timescale 1ns/1ps
// ****
// stack ram behind the sequencer
// ****
module mic_stack_model (
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic        re,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata
);
    logic [7:0] mem_r [256];
    logic [7:0] rd_r;
    assign rdata = rd_r;
    // only the low byte decodes, so the page wraps like the pointer
    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[addr[7:0]] <= wdata;
        end
    end
    // data one cycle after the strobe; toggles otherwise so stale bytes never pass
    always_ff @(posedge clk) begin
        if (re) begin
            rd_r <= mem_r[addr[7:0]];
        end else begin
            rd_r <= ~rd_r;
        end
    end
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "mic_defs.svh"
// ****
// self-checking bench
// ****
module testbench;
    logic        MCLK = '0, RST = '1, HSEL = '0, HWRITE = '0, INSN_DONE = '0;
    logic        TRAP_REQ = '0, RETURN_FROM_INTERRUPT_REQ = '0, WFI_REQ = '0, HALT_REQ = '0;
    logic        MASK_SET = '0, MASK_CLR = '0, m = '1;
    logic [1:0]  HTRANS = '0;
    logic [31:0] HADDR = '0, HWDATA = '0;
    logic [15:0] PC_IN = '0;
    logic [7:0]  X_IN = '0, A_IN = '0, CC_IN = '0, SP_IN = '0;
    logic [4:0]  PER_SET = '0, PER_CLR = '0, PER_IE = '0;
    logic [14:0] pins = 15'h7FFF, ien = '0;
    logic [39:0] sv[$];
    int          bad_count = 0, cmp_count = 0, wk = 0;
    wire  [31:0] HRDATA;
    wire  [15:0] STK_ADDR, PC_NEW;
    wire  [7:0]  STK_RDATA, STK_WDATA, X_OUT, A_OUT, CC_OUT, SP_OUT;
    wire         HREADYOUT, STK_WE, STK_RE, CPU_HOLD, PC_LOAD, CTX_LOAD;
    wire         SP_LOAD, I_MASK, WAKE, HRESP;
    // service order: external lines, then peripherals
    logic [15:0] vt[9] = '{16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEC,
                           16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4};
    logic [14:0] gm[4] = '{15'h000F, 15'h0070, 15'h0780, 15'h7800};

    mic_interrupt_controller i_dut (
        .MCLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .INSN_DONE, .TRAP_REQ,
        .RETURN_FROM_INTERRUPT_REQ, .WFI_REQ, .HALT_REQ, .MASK_SET, .MASK_CLR, .PC_IN, .X_IN, .A_IN,
        .CC_IN, .SP_IN, .PA_PIN(pins[3:0]), .PA_IEN(ien[3:0]), .PF_PIN(pins[6:4]),
        .PF_IEN(ien[6:4]), .PB_PIN(pins[14:7]), .PB_IEN(ien[14:7]), .PER_SET,
        .PER_CLR, .PER_IE, .STK_RDATA, .STK_WE, .STK_RE, .STK_ADDR, .STK_WDATA,
        .CPU_HOLD, .PC_LOAD, .PC_NEW, .CTX_LOAD, .X_OUT, .A_OUT, .CC_OUT, .SP_LOAD,
        .SP_OUT, .I_MASK, .WAKE
    );
    mic_stack_model i_stk (.clk(MCLK), .we(STK_WE), .re(STK_RE), .addr(STK_ADDR),
        .wdata(STK_WDATA), .rdata(STK_RDATA));

    initial begin
        forever #10 MCLK = ~MCLK;
    end

    task automatic final_report();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic tmo();
        bad_count++;
        final_report();
    endtask

    task automatic rdy();
        int n;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 20);
        if (HREADYOUT !== 1'b1) tmo();
    endtask

    // one word transfer; read data taken at the end of the data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HADDR <= 32'(a);
        HWRITE <= w;
        rdy();
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        rdy();
        chk(64'(HRESP), 64'h0);
        if (!w) chk(64'(HRDATA), 64'(e));
    endtask

    // no push, no vector load, no wake may follow
    task automatic idle(input bit id);
        repeat (4) @(posedge MCLK);
        INSN_DONE <= id;
        @(posedge MCLK) INSN_DONE <= 1'h0;
        repeat (8) begin
            @(negedge MCLK);
            chk(64'({STK_WE, PC_LOAD, WAKE}), 64'h0);
        end
        @(posedge MCLK);
    endtask

    // entry with fresh core state; the saved frame goes on the bench's queue
    task automatic entry(input logic [15:0] v, input bit id);
        logic [7:0] d[5];
        int k;
        k = 0;
        wk = 0;
        PC_IN <= 16'($urandom);
        X_IN <= 8'($urandom);
        A_IN <= 8'($urandom);
        CC_IN <= 8'($urandom);
        if (id) repeat (4) @(posedge MCLK);
        INSN_DONE <= id;
        @(posedge MCLK) INSN_DONE <= 1'h0;
        PER_SET <= 5'h00;
        d = '{PC_IN[7:0], PC_IN[15:8], X_IN, A_IN, {CC_IN[7:4], m, CC_IN[2:0]}};
        sv.push_back({PC_IN, X_IN, A_IN, d[4]});
        for (int n = 0; n < 30 && PC_LOAD !== 1'b1; n++) begin
            @(negedge MCLK);
            if (WAKE === 1'b1) wk++;
            if (STK_WE === 1'b1) begin
                chk(64'({CPU_HOLD, STK_ADDR, STK_WDATA}),
                    64'({1'b1, 8'h01, SP_IN - 8'(k), d[k % 5]}));
                k++;
            end
        end
        if (PC_LOAD !== 1'b1) tmo();
        chk(64'({PC_NEW, SP_OUT, 3'(k), SP_LOAD, CTX_LOAD}),
            64'({v, SP_IN - 8'h05, 3'h5, 2'h2}));
        if (id) chk(64'(wk), 64'h0);
        m = 1'h1;
        @(negedge MCLK);
        chk(64'(I_MASK), 64'(m));
        @(posedge MCLK);
        SP_IN <= SP_OUT;
        PC_IN <= v;
    endtask

    task automatic return_from_interrupt();
        logic [39:0] s;
        s = sv.pop_back();
        RETURN_FROM_INTERRUPT_REQ <= 1'h1;
        @(posedge MCLK) RETURN_FROM_INTERRUPT_REQ <= 1'h0;
        for (int n = 0; n < 30 && CTX_LOAD !== 1'b1; n++) @(negedge MCLK);
        if (CTX_LOAD !== 1'b1) tmo();
        chk(64'({PC_NEW, X_OUT, A_OUT, CC_OUT, SP_OUT, PC_LOAD, SP_LOAD}),
            64'({s, SP_IN + 8'h05, 2'h3}));
        m = s[3];
        @(negedge MCLK);
        chk(64'(I_MASK), 64'(m));
        @(posedge MCLK);
        SP_IN <= SP_IN + 8'h05;
        PC_IN <= s[39:24];
    endtask

    // main sequence
    initial begin
        void'($urandom(7));
        SP_IN <= 8'($urandom);
        repeat (12) @(posedge MCLK);
        RST <= 1'h0;
        @(posedge MCLK);
        ahb(0, `MIC_OFF_CTRL, 0, 0);
        ahb(1, `MIC_OFF_CTRL, 1, 0);
        ahb(0, `MIC_OFF_CTRL, 0, 1);
        ahb(0, 8'h40, 0, 0);
        // trap while masked, then unmasking inside it admits a held request
        PER_IE <= 5'h01;
        PER_SET <= 5'h01;
        TRAP_REQ <= 1'h1;
        @(posedge MCLK) PER_SET <= 5'h00;
        TRAP_REQ <= 1'h0;
        idle(0);
        entry(16'hFFFC, 1);
        MASK_CLR <= 1'h1;
        m = 1'h0;
        @(posedge MCLK) MASK_CLR <= 1'h0;
        entry(16'hFFEC, 1);
        PER_CLR <= 5'h01;
        @(posedge MCLK) PER_CLR <= 5'h00;
        return_from_interrupt();
        return_from_interrupt();
        // rising edge on line 0 needs every enabled pin of the group high
        MASK_CLR <= 1'h1;
        m = 1'h0;
        @(posedge MCLK) MASK_CLR <= 1'h0;
        pins <= 15'h7FF0;
        ien <= 15'h0003;
        idle(1);
        pins <= 15'h7FF1;
        idle(1);
        pins <= 15'h7FF3;
        entry(16'hFFF6, 1);
        return_from_interrupt();
        idle(1);
        ahb(1, `MIC_OFF_CTRL, 3, 0);
        pins <= 15'h7FF0;
        entry(16'hFFF6, 1);
        return_from_interrupt();
        // everything pending at once: lines 0/1 level, lines 2/3 falling edge only
        ahb(1, `MIC_OFF_CTRL, 8, 0);
        pins <= 15'h0000;
        ien <= 15'h7FFF;
        PER_IE <= 5'h1F;
        PER_SET <= 5'h1F;
        TRAP_REQ <= 1'h1;
        @(posedge MCLK) PER_SET <= 5'h00;
        TRAP_REQ <= 1'h0;
        entry(16'hFFFC, 1);
        return_from_interrupt();
        for (int j = 0; j < 9; j++) begin
            entry(vt[j], 1);
            if (j < 4) pins <= pins | gm[j];
            else PER_CLR <= 5'(1 << (j - 4));
            @(posedge MCLK) PER_CLR <= 5'h00;
            return_from_interrupt();
        end
        // a disabled flag stays latched until the clear sequence drops it
        PER_IE <= 5'h00;
        PER_SET <= 5'h02;
        @(posedge MCLK) PER_SET <= 5'h00;
        idle(1);
        ahb(0, `MIC_OFF_STAT, 0, 32'h40);
        PER_CLR <= 5'h02;
        @(posedge MCLK) PER_CLR <= 5'h00;
        PER_IE <= 5'h1F;
        idle(1);
        // halt ignores peripherals, wakes on an external line; wait wakes on any
        HALT_REQ <= 1'h1;
        m = 1'h0;
        @(posedge MCLK) HALT_REQ <= 1'h0;
        PER_SET <= 5'h01;
        @(posedge MCLK) PER_SET <= 5'h00;
        idle(0);
        pins <= 15'h7F7F;
        entry(16'hFFF2, 0);
        chk(64'(wk), 64'h1);
        pins <= 15'h7FFF;
        PER_CLR <= 5'h01;
        @(posedge MCLK) PER_CLR <= 5'h00;
        return_from_interrupt();
        WFI_REQ <= 1'h1;
        m = 1'h0;
        @(posedge MCLK) WFI_REQ <= 1'h0;
        PER_SET <= 5'h08;
        entry(16'hFFE6, 0);
        chk(64'(wk), 64'h1);
        PER_CLR <= 5'h08;
        @(posedge MCLK) PER_CLR <= 5'h00;
        return_from_interrupt();
        final_report();
    end
endmodule
